/* mcs_sync_regs.svh */
// Register offsets, field positions and timing counts of the sync block
`ifndef MCS_SYNC_REGS_SVH
`define MCS_SYNC_REGS_SVH

`define MCS_OFF_CLKDIV      12'h10b
`define MCS_OFF_REFCTL      12'h120
`define MCS_OFF_IGNCNT      12'h121
`define MCS_OFF_TSDELAY     12'h123
`define MCS_OFF_MONITOR     12'h128
`define MCS_OFF_SYNCSEL     12'h1ff
`define MCS_OFF_CBFUNC      12'h559
`define MCS_OFF_CBCOUNT     12'h58f

`define MCS_RST_BYTE        8'h00
`define MCS_REFCTL_MODE_LSB 1
`define MCS_REFCTL_EDGE_BIT 3
`define MCS_REFCTL_TRAN_BIT 4
`define MCS_MODE_OFF        2'h0
`define MCS_MODE_CONT       2'h1
`define MCS_MODE_NSHOT      2'h2
`define MCS_CBFUNC_REF      3'h5
`define MCS_CBCOUNT_BAD     2'h3
`define MCS_IGN_MAX         5'h10

`define MCS_MON_SETUP_OK    4'h8
`define MCS_MON_HOLD_OK     4'h8
`define MCS_MON_HOLD_ERR    4'hf
`define MCS_MON_MIN_STABLE  4'h2
`define MCS_LMFC_CYCLES     8'h20

`define MCS_APB_CMD         8'h00
`define MCS_APB_STAT        8'h04
`define MCS_APB_PULSE       8'h08
`define MCS_APB_MARKS       8'h0c
`define MCS_PULSE_MIN       8'h02

`endif

/* mcs_pkg.sv */
// State types of the two ends of the sync link, one type for each end
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_DISARMED = 2'b01,
    MCS_ARMED    = 2'b10
  } mcs_cap_state_t;

  typedef enum logic [2:0] {
    MCS_H_IDLE = 3'b001,
    MCS_H_BUSY = 3'b010,
    MCS_H_WAIT = 3'b100
  } mcs_host_state_t;
endpackage

/* mcs_link_if.sv */
// Signals between the converter sync logic and the controlling logic device
interface mcs_link_if;
  logic        ref_pulse;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [31:0] smp_data;
  logic [1:0]  smp_ctrl;
  logic        lmfc_tick;

  modport dev (input ref_pulse, reg_wr, reg_rd, reg_addr, reg_wdata,
               output reg_rdata, reg_rvalid, smp_data, smp_ctrl, lmfc_tick);
  modport host (output ref_pulse, reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_rvalid, smp_data, smp_ctrl, lmfc_tick);
endinterface

/* mcs_ref_capture.sv */
// Reference synchroniser, qualifying-edge detector and window monitor
`include "mcs_sync_regs.svh"
module mcs_ref_capture
  import mcs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ref_i,
  input  wire logic       late_edge_i,
  input  wire logic       fall_sel_i,
  output logic            event_o,
  output logic [7:0]      mon_o
);
  logic       sync1, sync2, sync3, prev;
  logic       next_prev;
  logic [3:0] stable;
  logic [3:0] next_stable;
  logic       pend;
  logic       next_pend;
  logic [7:0] next_mon;
  logic       lvl;

  always_comb
  begin
    lvl = late_edge_i ? sync3 : sync2; // R16
    next_prev = lvl;
    event_o = fall_sel_i ? (prev & ~lvl) : (~prev & lvl); // R15
    next_stable = (lvl != prev) ? 4'h0 : ((stable == 4'hf) ? stable : stable + 4'h1);
    next_pend = event_o;
    next_mon = mon_o;
    if (event_o)
    begin
      // Short prior level: setup margin too small
      if (stable < `MCS_MON_MIN_STABLE)
        next_mon = {4'h0, stable}; // R19
      else if (stable > 4'h8)
        next_mon = {`MCS_MON_HOLD_OK, `MCS_MON_SETUP_OK | 4'h7}; // R21
      else
        next_mon = {`MCS_MON_HOLD_OK, `MCS_MON_SETUP_OK | (stable - 4'h2)}; // R18
    end
    else if (pend && lvl == prev && stable == 4'h0)
      next_mon = mon_o;
    else if (pend && lvl != prev)
      next_mon = {`MCS_MON_HOLD_ERR, 4'h0}; // R20
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1  <= 1'b0;
      sync2  <= 1'b0;
      sync3  <= 1'b0;
      prev   <= 1'b0;
      stable <= 4'h0;
      pend   <= 1'b0;
      mon_o  <= 8'h00;
    end
    else
    begin
      sync1  <= ref_i;
      sync2  <= sync1;
      sync3  <= sync2;
      prev   <= next_prev;
      stable <= next_stable;
      pend   <= next_pend;
      mon_o  <= next_mon; // R22
    end
  end
endmodule

/* mcs_dev_end.sv */
// Converter-side sync logic: registers, capture control, resync, timestamp
//
// Notes on behaviour
// R1 - Sync mode bit 0 selects normal/timestamp
// R2 - Normal mode: event resyncs divider, monitor, link
// R3 - Timestamp mode: no clock reset, sample marked
// R4 - Timestamp needs continuous or N-shot mode
// R5 - Timestamp needs control bit count 00-10
// R6 - Control bit 0 function 101 carries mark
// R7 - Seven-bit delay moves the marked sample
// R8 - No timestamp while decimating
// R9 - All channels share one pipeline latency
// R10 - Nonzero mode field arms capture
// R11 - N-shot clears mode field after capture
// R12 - Reference pulse at least two divided periods (the host enforces only two core clock cycles)
// R13 - Continuous period multiple of multiframe clock
// R14 - Prefer single or N-shot reference
// R15 - Transition bit picks rising or falling event
// R16 - Edge bit picks capturing clock edge
// R17 - N-shot ignores up to 16 events
// R18 - Monitor holds hold and setup status
// R19 - Hold 0, setup 0-7: setup error
// R20 - Setup 0, hold 9-F: hold error
// R21 - Hold 8, setup 9-F: best margin
// R22 - Monitor tells whether reference was captured
// R23 - Ignore counter decrements, then one capture
// R24 - Mark only on the coinciding delayed sample
//
// The implementer's own choice: the APB interface to the registers.
`include "mcs_sync_regs.svh"
module mcs_dev_end
  import mcs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  mcs_link_if.dev          link,
  input  wire logic [31:0] adc_data_i,
  input  wire logic        decimation_i,
  output logic             div_tick_o,
  output logic             resync_o,
  output logic [1:0]       ref_mode_o
);
  logic [7:0]     clkdiv, refctl, igncnt, tsdelay, syncsel, cbfunc, cbcount;
  logic [7:0]     next_clkdiv, next_refctl, next_igncnt, next_tsdelay;
  logic [7:0]     next_syncsel, next_cbfunc, next_cbcount;
  logic [7:0]     next_rdata;
  logic           next_rvalid;
  logic [4:0]     ign_left;
  logic [4:0]     next_ign_left;
  mcs_cap_state_t state;
  mcs_cap_state_t next_state;
  logic [2:0]     div_cnt;
  logic [2:0]     next_div_cnt;
  logic [7:0]     lmfc_cnt;
  logic [7:0]     next_lmfc_cnt;
  logic [127:0]   ts_line;
  logic [127:0]   next_ts_line;
  logic [31:0]    next_smp_data;
  logic [1:0]     next_smp_ctrl;
  logic           next_resync;
  logic           ref_event;
  logic [7:0]     mon;
  logic           capture;
  logic           ts_enable;
  logic           ts_mark;
  logic [2:0]     div_mask;
  logic [1:0]     mode;

  function automatic logic [2:0] div_mask_of(input logic [2:0] sel);
    case (sel)
      3'h1:    div_mask_of = 3'h1;
      3'h2:    div_mask_of = 3'h3;
      3'h3:    div_mask_of = 3'h7;
      default: div_mask_of = 3'h0;
    endcase
  endfunction

  mcs_ref_capture u_capture (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ref_i       (link.ref_pulse), // R12
    .late_edge_i (refctl[`MCS_REFCTL_EDGE_BIT]),
    .fall_sel_i  (refctl[`MCS_REFCTL_TRAN_BIT]),
    .event_o     (ref_event),
    .mon_o       (mon)
  );

  assign mode       = refctl[`MCS_REFCTL_MODE_LSB +: 2];
  assign ref_mode_o = mode;
  assign div_mask   = div_mask_of(clkdiv[2:0]);
  assign div_tick_o = (div_cnt & div_mask) == 3'h0;

  // Capture state machine
  always_comb
  begin
    next_state = state;
    next_ign_left = ign_left;
    capture = 1'b0;
    case (state)
      MCS_DISARMED:
        if (mode != `MCS_MODE_OFF)
          next_state = MCS_ARMED; // R10
      MCS_ARMED:
      begin
        if (mode == `MCS_MODE_OFF)
          next_state = MCS_DISARMED;
        else if (ref_event)
        begin
          if (mode == `MCS_MODE_NSHOT && ign_left != 5'h0)
            next_ign_left = ign_left - 5'h1; // R17 R23
          else
          begin
            capture = 1'b1; // R23
            if (mode == `MCS_MODE_NSHOT)
              next_state = MCS_DISARMED;
          end
        end
      end
      default: next_state = MCS_DISARMED;
    endcase
    if (link.reg_wr && link.reg_addr == `MCS_OFF_REFCTL)
      next_ign_left = (igncnt[4:0] > `MCS_IGN_MAX) ? `MCS_IGN_MAX : igncnt[4:0];
  end

  // Register file
  always_comb
  begin
    next_clkdiv  = clkdiv;
    next_refctl  = refctl;
    next_igncnt  = igncnt;
    next_tsdelay = tsdelay;
    next_syncsel = syncsel;
    next_cbfunc  = cbfunc;
    next_cbcount = cbcount;
    if (capture && mode == `MCS_MODE_NSHOT)
      next_refctl[`MCS_REFCTL_MODE_LSB +: 2] = `MCS_MODE_OFF; // R11
    if (link.reg_wr)
    begin
      case (link.reg_addr)
        `MCS_OFF_CLKDIV:  next_clkdiv  = link.reg_wdata;
        `MCS_OFF_REFCTL:  next_refctl  = link.reg_wdata;
        `MCS_OFF_IGNCNT:  next_igncnt  = link.reg_wdata;
        `MCS_OFF_TSDELAY: next_tsdelay = link.reg_wdata;
        `MCS_OFF_SYNCSEL: next_syncsel = link.reg_wdata;
        `MCS_OFF_CBFUNC:  next_cbfunc  = link.reg_wdata;
        `MCS_OFF_CBCOUNT: next_cbcount = link.reg_wdata;
        default:          next_clkdiv  = clkdiv;
      endcase
    end
    next_rvalid = link.reg_rd;
    case (link.reg_addr)
      `MCS_OFF_CLKDIV:  next_rdata = clkdiv;
      `MCS_OFF_REFCTL:  next_rdata = refctl;
      `MCS_OFF_IGNCNT:  next_rdata = igncnt;
      `MCS_OFF_TSDELAY: next_rdata = tsdelay;
      `MCS_OFF_MONITOR: next_rdata = mon; // R18
      `MCS_OFF_SYNCSEL: next_rdata = syncsel;
      `MCS_OFF_CBFUNC:  next_rdata = cbfunc;
      `MCS_OFF_CBCOUNT: next_rdata = cbcount;
      default:          next_rdata = 8'h00;
    endcase
  end

  // Resync of divider and multiframe counter, timestamp delay line
  always_comb
  begin
    next_resync = capture && !syncsel[0]; // R1 R2
    next_div_cnt = next_resync ? 3'h0 : div_cnt + 3'h1;
    if (next_resync || lmfc_cnt == `MCS_LMFC_CYCLES - 8'h1)
      next_lmfc_cnt = 8'h00;
    else
      next_lmfc_cnt = lmfc_cnt + 8'h01;
    // Mark settings the far side must program are checked, not trusted
    ts_enable = syncsel[0]
                && cbfunc[2:0] == `MCS_CBFUNC_REF
                && cbcount[7:6] != `MCS_CBCOUNT_BAD
                && !decimation_i; // R3 R4 R5 R6 R8
    next_ts_line = {ts_line[126:0], capture && ts_enable};
    // Delay 0 marks the sample of the capture cycle itself
    ts_mark = (tsdelay[6:0] == 7'h00) ? (capture && ts_enable)
                                      : ts_line[tsdelay[6:0] - 7'h01]; // R7 R24
    next_smp_data = adc_data_i; // R9
    next_smp_ctrl = {1'b0, ts_mark && syncsel[0]}; // R3
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clkdiv          <= `MCS_RST_BYTE;
      refctl          <= `MCS_RST_BYTE;
      igncnt          <= `MCS_RST_BYTE;
      tsdelay         <= `MCS_RST_BYTE;
      syncsel         <= `MCS_RST_BYTE; // R1
      cbfunc          <= `MCS_RST_BYTE;
      cbcount         <= `MCS_RST_BYTE;
      link.reg_rdata  <= 8'h00;
      link.reg_rvalid <= 1'b0;
      state           <= MCS_DISARMED;
      ign_left        <= 5'h00;
      div_cnt         <= 3'h0;
      lmfc_cnt        <= 8'h00;
      ts_line         <= '0;
      link.smp_data   <= 32'h0000_0000;
      link.smp_ctrl   <= 2'h0;
      link.lmfc_tick  <= 1'b0;
      resync_o        <= 1'b0;
    end
    else
    begin
      clkdiv          <= next_clkdiv;
      refctl          <= next_refctl;
      igncnt          <= next_igncnt;
      tsdelay         <= next_tsdelay;
      syncsel         <= next_syncsel;
      cbfunc          <= next_cbfunc;
      cbcount         <= next_cbcount;
      link.reg_rdata  <= next_rdata;
      link.reg_rvalid <= next_rvalid;
      state           <= next_state;
      ign_left        <= next_ign_left;
      div_cnt         <= next_div_cnt; // R2
      lmfc_cnt        <= next_lmfc_cnt; // R2
      ts_line         <= next_ts_line;
      link.smp_data   <= next_smp_data;
      link.smp_ctrl   <= next_smp_ctrl;
      link.lmfc_tick  <= next_lmfc_cnt == 8'h00;
      resync_o        <= next_resync; // R2
    end
  end
endmodule

/* mcs_host_end.sv */
// Controlling logic device: APB registers, register access, reference pulses
`include "mcs_sync_regs.svh"
module mcs_host_end
  import mcs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  mcs_link_if.host         link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mark_o
);
  mcs_host_state_t state;
  mcs_host_state_t next_state;
  logic [31:0] cmd;
  logic [31:0] next_cmd;
  logic [7:0]  rd_byte;
  logic [7:0]  next_rd_byte;
  logic [7:0]  pulse_left;
  logic [7:0]  next_pulse_left;
  logic [15:0] marks;
  logic [15:0] next_marks;
  logic        next_mark;
  logic        apb_wr;
  logic        apb_rd;
  logic        mapped;

  assign pready_o = 1'b1;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign mapped = paddr_i == `MCS_APB_CMD || paddr_i == `MCS_APB_STAT
                  || paddr_i == `MCS_APB_PULSE || paddr_i == `MCS_APB_MARKS;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign link.ref_pulse = pulse_left != 8'h00;
  assign link.reg_wr    = state == MCS_H_BUSY && cmd[31];
  assign link.reg_rd    = state == MCS_H_BUSY && !cmd[31];
  assign link.reg_addr  = cmd[27:16];
  assign link.reg_wdata = cmd[7:0];

  always_comb
  begin
    case (paddr_i)
      `MCS_APB_CMD:   prdata_o = cmd;
      `MCS_APB_STAT:  prdata_o = {23'h0, state != MCS_H_IDLE, rd_byte};
      `MCS_APB_PULSE: prdata_o = {24'h0, pulse_left};
      `MCS_APB_MARKS: prdata_o = {16'h0, marks};
      default:        prdata_o = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_rd_byte = rd_byte;
    case (state)
      MCS_H_IDLE:
        if (apb_wr && paddr_i == `MCS_APB_CMD)
        begin
          next_cmd = pwdata_i;
          next_state = MCS_H_BUSY;
        end
      MCS_H_BUSY:
        next_state = cmd[31] ? MCS_H_IDLE : MCS_H_WAIT;
      MCS_H_WAIT:
        if (link.reg_rvalid)
        begin
          next_rd_byte = link.reg_rdata;
          next_state = MCS_H_IDLE;
        end
      default: next_state = MCS_H_IDLE;
    endcase
    next_pulse_left = (pulse_left != 8'h00) ? pulse_left - 8'h01 : 8'h00;
    // Too short a pulse could be missed by the converter
    if (apb_wr && paddr_i == `MCS_APB_PULSE && pulse_left == 8'h00)
      next_pulse_left = (pwdata_i[7:0] < `MCS_PULSE_MIN) ? `MCS_PULSE_MIN : pwdata_i[7:0]; // R12 R14
    next_mark = link.smp_ctrl[0]; // R6 R24
    next_marks = marks;
    // A mark landing in the clear cycle still counts
    if (apb_wr && paddr_i == `MCS_APB_MARKS)
      next_marks = {15'h0000, link.smp_ctrl[0]};
    else if (link.smp_ctrl[0])
      next_marks = marks + 16'h0001;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state      <= MCS_H_IDLE;
      cmd        <= 32'h0000_0000;
      rd_byte    <= 8'h00;
      pulse_left <= 8'h00;
      marks      <= 16'h0000;
      mark_o     <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cmd        <= next_cmd;
      rd_byte    <= next_rd_byte;
      pulse_left <= next_pulse_left;
      marks      <= next_marks;
      mark_o     <= next_mark;
    end
  end
endmodule

/* mcs_link_props.sv */
// Assertions on the link between the converter end and the controller end
`include "mcs_sync_regs.svh"
module mcs_link_props
(
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        ref_pulse,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic [1:0]  smp_ctrl,
  input wire logic        lmfc_tick
);
  logic sync_on;
  logic cbf_on;
  logic next_sync_on;
  logic next_cbf_on;

  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Shadow of the last written sync mode and mark function
  always_comb
  begin
    next_sync_on = sync_on;
    next_cbf_on  = cbf_on;
    if (reg_wr && reg_addr == `MCS_OFF_SYNCSEL)
      next_sync_on = reg_wdata[0];
    if (reg_wr && reg_addr == `MCS_OFF_CBFUNC)
      next_cbf_on = reg_wdata[2:0] == `MCS_CBFUNC_REF;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_on <= 1'b0;
      cbf_on  <= 1'b0;
    end
    else
    begin
      sync_on <= next_sync_on;
      cbf_on  <= next_cbf_on;
    end
  end

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("register read got no answer");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read");
  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("write and read strobes together");
  ref_width_a: assert property ($rose(ref_pulse) |=> ref_pulse)
    else $error("reference pulse shorter than two cycles");
  ctrl_spare_a: assert property (smp_ctrl[1] == 1'b0)
    else $error("spare control bit set");
  mark_pulse_a: assert property (smp_ctrl[0] |=> !smp_ctrl[0])
    else $error("mark longer than one sample");
  mark_enable_a: assert property (smp_ctrl[0] |-> sync_on && cbf_on)
    else $error("mark outside timestamp setup");
  // Timestamp mode must leave the multiframe clock running untouched
  lmfc_steady_a: assert property (lmfc_tick && sync_on |-> ##32 (lmfc_tick || !sync_on))
    else $error("multiframe clock moved in timestamp mode");
endmodule

/* tb_top.sv */
// Bench joining both sync ends, driven over APB
`include "mcs_sync_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) \
  begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        dec = 1'b0;
  logic        ref_q = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] adc = 32'h0;
  logic [31:0] adc_q = 32'h0;
  logic [31:0] seed = 32'hc;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        resync;
  logic        div_tick;
  logic        mark_out;
  logic        mark_q = 1'b0;
  logic [1:0]  ref_mode;
  logic [11:0] offs [7] = '{`MCS_OFF_CLKDIV, `MCS_OFF_REFCTL, `MCS_OFF_TSDELAY, `MCS_OFF_MONITOR,
                            `MCS_OFF_SYNCSEL, `MCS_OFF_CBFUNC, `MCS_OFF_CBCOUNT};
  logic [11:0] bad_a [3] = '{`MCS_OFF_CBFUNC, `MCS_OFF_CBCOUNT, `MCS_OFF_CBFUNC};
  logic [7:0]  bad_v [3] = '{8'h05, 8'hc0, 8'h04};
  logic [7:0]  good_v [3] = '{8'h05, 8'h40, 8'h05};
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          res_n = 0;
  int          mark_n = 0;
  int          rise_c, fall_c, res_c, mark_c;

  mcs_link_if mcs_link_if_i ();
  mcs_dev_end mcs_dev_end_i (.core_clk_i(clk), .rstn_i(rstn), .link(mcs_link_if_i), .adc_data_i(adc),
    .decimation_i(dec), .div_tick_o(div_tick), .resync_o(resync), .ref_mode_o(ref_mode));
  mcs_host_end mcs_host_end_i (.core_clk_i(clk), .rstn_i(rstn), .link(mcs_link_if_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mark_o(mark_out));
  mcs_link_props mcs_link_props_i (.core_clk_i(clk), .rstn_i(rstn), .ref_pulse(mcs_link_if_i.ref_pulse),
    .reg_wr(mcs_link_if_i.reg_wr), .reg_rd(mcs_link_if_i.reg_rd), .reg_addr(mcs_link_if_i.reg_addr),
    .reg_wdata(mcs_link_if_i.reg_wdata), .reg_rvalid(mcs_link_if_i.reg_rvalid),
    .smp_ctrl(mcs_link_if_i.smp_ctrl), .lmfc_tick(mcs_link_if_i.lmfc_tick));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Cycles from the qualifying reference edge to its effect
  function automatic int lat(input logic late, input int d);
    return (late ? 4 : 3) + d;
  endfunction

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Device register access; busy must drop before the next command
  task automatic dev_acc(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `MCS_APB_CMD, {w, 3'h0, a, 8'h00, d}, r, e);
    do
      apb(1'b0, `MCS_APB_STAT, 32'h0, r, e);
    while (r[8] !== 1'b0);
    q = r[7:0];
  endtask

  task automatic pulse(input int w);
    logic [31:0] r;
    logic        e;
    do
      @(posedge clk);
    while (mcs_link_if_i.lmfc_tick !== 1'b1);
    apb(1'b1, `MCS_APB_PULSE, w, r, e);
    do
      apb(1'b0, `MCS_APB_PULSE, 32'h0, r, e);
    while (r !== 32'h0);
    repeat (16) @(posedge clk);
  endtask

  initial
    forever #4 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    adc   <= rnd();
    adc_q <= adc;
    ref_q <= mcs_link_if_i.ref_pulse;
    mark_q <= mcs_link_if_i.smp_ctrl[0];
    if (mcs_link_if_i.ref_pulse && !ref_q)
      rise_c = cyc;
    if (!mcs_link_if_i.ref_pulse && ref_q)
      fall_c = cyc;
    if (resync === 1'b1)
      res_n++;
    if (resync === 1'b1)
    begin
      res_c = cyc;
      `CHK("div restart", 1'b1, div_tick)
      `CHK("lmfc restart", 1'b1, mcs_link_if_i.lmfc_tick)
    end
    if (rstn)
      `CHK("mark_o", mark_q, mark_out)
    if (mcs_link_if_i.smp_ctrl[0] === 1'b1)
      mark_n++;
    if (mcs_link_if_i.smp_ctrl[0] === 1'b1)
      mark_c = cyc;
    if (rstn && cyc > 12)
      `CHK("smp_data", adc_q, mcs_link_if_i.smp_data)
    if (cyc > 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  b;
    logic [7:0]  v;
    int          k;
    int          d;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[i])
    begin
      dev_acc(1'b0, offs[i], 8'h00, b);
      `CHK("reset", 8'h00, b);
    end
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e);
    `CHK("unmapped data", 32'h0, r);
    dev_acc(1'b1, `MCS_OFF_MONITOR, 8'hff, b);
    dev_acc(1'b0, `MCS_OFF_MONITOR, 8'h00, b);
    `CHK("monitor ro", 8'h00, b);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 1 || i == 3)
        continue;
      v = 8'(rnd()) & 8'h7f;
      dev_acc(1'b1, offs[i], v, b);
      dev_acc(1'b0, offs[i], 8'h00, b);
      `CHK("readback", v, b);
      dev_acc(1'b1, offs[i], 8'h00, b);
    end
    // Normal mode, N-shot with random edges; last round skips the most
    for (int t = 0; t < 4; t++)
    begin
      r = rnd();
      k = (t == 3) ? 16 : int'(r[1:0]);
      dev_acc(1'b1, `MCS_OFF_IGNCNT, 8'(k), b);
      dev_acc(1'b1, `MCS_OFF_REFCTL, {3'h0, r[4:3], `MCS_MODE_NSHOT, 1'b0}, b);
      `CHK("armed", `MCS_MODE_NSHOT, ref_mode);
      res_n = 0;
      repeat (k) pulse(2);
      `CHK("ignored", 0, res_n);
      // Two-cycle high before a falling event leaves little setup margin
      if (k > 0 && r[4])
      begin
        dev_acc(1'b0, `MCS_OFF_MONITOR, 8'h00, b);
        `CHK("setup margin", 8'h01, b);
      end
      pulse(4 + t);
      `CHK("resync", 1, res_n);
      `CHK("self clear", `MCS_MODE_OFF, ref_mode);
      `CHK("capture delay", lat(r[3], 0), res_c - (r[4] ? fall_c : rise_c));
      dev_acc(1'b0, `MCS_OFF_MONITOR, 8'h00, b);
      `CHK("captured", 1'b1, b != 8'h00);
      if (!r[4])
        `CHK("margin", 8'h8f, b);
    end
    // Timestamp mode on a continuous reference
    d = int'(rnd() & 32'h7);
    dev_acc(1'b1, `MCS_OFF_SYNCSEL, 8'h01, b);
    dev_acc(1'b1, `MCS_OFF_CBFUNC, 8'h05, b);
    dev_acc(1'b1, `MCS_OFF_CBCOUNT, 8'h40, b);
    dev_acc(1'b1, `MCS_OFF_TSDELAY, 8'(d), b);
    dev_acc(1'b1, `MCS_OFF_REFCTL, {5'h0, `MCS_MODE_CONT, 1'b0}, b);
    apb(1'b1, `MCS_APB_MARKS, 32'h0, r, e);
    res_n = 0;
    mark_n = 0;
    pulse(3);
    `CHK("marks", 1, mark_n);
    `CHK("no resync", 0, res_n);
    `CHK("mark delay", lat(1'b0, d), mark_c - rise_c);
    `CHK("stays armed", `MCS_MODE_CONT, ref_mode);
    apb(1'b0, `MCS_APB_MARKS, 32'h0, r, e);
    `CHK("mark counter", 32'h1, r);
    // Decimation, bad count, wrong function: each blocks the mark
    for (int i = 0; i < 3; i++)
    begin
      dec <= (i == 0);
      dev_acc(1'b1, bad_a[i], bad_v[i], b);
      mark_n = 0;
      pulse(3);
      `CHK("suppressed", 0, mark_n);
      dec <= 1'b0;
      dev_acc(1'b1, bad_a[i], good_v[i], b);
    end
    dev_acc(1'b1, `MCS_OFF_SYNCSEL, 8'h00, b);
    dev_acc(1'b1, `MCS_OFF_CLKDIV, 8'h01, b);
    res_n = 0;
    mark_n = 0;
    pulse(4);
    `CHK("normal resync", 1, res_n);
    `CHK("normal no mark", 0, mark_n);
    report_and_stop();
  end
endmodule
